// *** ssb_pkg.sv ***
// package of register map, field positions and reset values for the serial status and bit-rate block
package ssb_pkg;
  // register byte offsets
  localparam logic [7:0] SSB_OFF_STATUS  = 8'h00;
  localparam logic [7:0] SSB_OFF_DIVISOR = 8'h04;
  localparam logic [7:0] SSB_OFF_CONTROL = 8'h08;
  localparam logic [7:0] SSB_OFF_TX_DATA = 8'h0c;
  localparam logic [7:0] SSB_OFF_RX_DATA = 8'h10;
  // status flag positions
  localparam int SSB_ST_TX_EMPTY = 7;
  localparam int SSB_ST_RX_FULL  = 6;
  localparam int SSB_ST_OVERRUN  = 5;
  localparam int SSB_ST_FRAMING  = 4;
  localparam int SSB_ST_PARITY   = 3;
  localparam int SSB_ST_TX_DONE  = 2;
  localparam int SSB_ST_RX_MPB   = 1;
  localparam int SSB_ST_TX_MPB   = 0;
  // control field positions
  localparam int SSB_CT_TX_EN    = 0;
  localparam int SSB_CT_RX_EN    = 1;
  localparam int SSB_CT_SKIP_EN  = 2;
  localparam int SSB_CT_SYNC     = 3;
  localparam int SSB_CT_PRESC_LO = 4;
  localparam int SSB_CT_PRESC_HI = 5;
  // reset values
  localparam logic [7:0] SSB_RST_STATUS  = 8'h84;
  localparam logic [7:0] SSB_RST_DIVISOR = 8'hff;
  localparam logic [5:0] SSB_RST_CONTROL = 6'h00;
  // bit-rate arithmetic: period = (N+1) * base * 4^n, base 32 async and 4 sync
  localparam logic [11:0] SSB_BASE_ASYNC = 12'h020;
  localparam logic [11:0] SSB_BASE_SYNC  = 12'h004;
  // receive buffer shape: data byte plus multiprocessor bit
  localparam int SSB_RX_WIDTH = 9;
  localparam int SSB_RX_DEPTH = 8;
endpackage

// *** ssb_fifo.sv ***
// first-in first-out buffer with valid/ready on both sides
`timescale 1ns/1ps
module ssb_fifo #(
  parameter int WIDTH = 9,
  parameter int DEPTH = 8
) (
  // clock and reset
  input  wire logic             i_clk,
  input  wire logic             i_sys_rst,
  // fill side
  input  wire logic             i_in_valid,
  output logic                  o_in_ready,
  input  wire logic [WIDTH-1:0] i_in_data,
  // drain side
  output logic                  o_out_valid,
  input  wire logic             i_out_ready,
  output logic      [WIDTH-1:0] o_out_data
);
  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    wr_ptr;
  logic [AW-1:0]    rd_ptr;
  logic [AW:0]      count;
  logic             push;
  logic             pop;

  assign o_in_ready  = (count != (AW+1)'(DEPTH));
  assign o_out_valid = (count != '0);
  assign o_out_data  = mem[rd_ptr];
  assign push        = i_in_valid & o_in_ready;
  assign pop         = o_out_valid & i_out_ready;

  always_ff @(posedge i_clk) begin
    if (push) begin
      mem[wr_ptr] <= i_in_data;
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count  <= '0;
    end else begin
      if (push) begin
        wr_ptr <= (wr_ptr == AW'(DEPTH-1)) ? '0 : wr_ptr + 1'b1;
      end
      if (pop) begin
        rd_ptr <= (rd_ptr == AW'(DEPTH-1)) ? '0 : rd_ptr + 1'b1;
      end
      count <= count + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
endmodule

// *** ssb_rate_gen.sv ***
// bit-rate generator: prescaler stage then divisor stage, one-cycle tick per bit period
`timescale 1ns/1ps
module ssb_rate_gen
  import ssb_pkg::*;
(
  // clock and reset
  input  wire logic       i_clk,
  input  wire logic       i_sys_rst,
  // settings
  input  wire logic       i_enable,
  input  wire logic       i_sync_mode,
  input  wire logic [1:0] i_presc_sel,
  input  wire logic [7:0] i_divisor,
  // tick out
  output logic            o_bit_tick
);
  import ssb_pkg::*;

  logic [11:0] presc_cnt;
  logic [7:0]  div_cnt;
  logic [11:0] presc_len;
  logic        presc_wrap;

  // base shifted by 2n gives base * 4^n
  assign presc_len  = (i_sync_mode ? SSB_BASE_SYNC : SSB_BASE_ASYNC) << {i_presc_sel, 1'b0};
  assign presc_wrap = (presc_cnt == presc_len - 12'h001);

  // counters are held at zero while idle so the first period after enable is full length
  always_ff @(posedge i_clk) begin
    if (i_sys_rst || !i_enable) begin
      presc_cnt  <= '0;
      div_cnt    <= '0;
      o_bit_tick <= 1'b0;
    end else begin
      o_bit_tick <= 1'b0;
      if (presc_wrap) begin
        presc_cnt <= '0;
        if (div_cnt >= i_divisor) begin
          div_cnt    <= '0;
          o_bit_tick <= 1'b1;
        end else begin
          div_cnt <= div_cnt + 8'h01;
        end
      end else begin
        presc_cnt <= presc_cnt + 12'h001;
      end
    end
  end
endmodule

// *** ssb_top.sv ***
// serial status flags, multiprocessor bits and bit-rate divisor behind an apb slave
//
// Notes on behaviour
// - writing one never sets clearable flags
// - tx empty resets one, sets on load
// - tx empty clears on write-zero or data
// - rx full sets when clean byte lands
// - rx full clears on write-zero or read
// - overrun sets on overrun, write-zero clears
// - framing flag sets on error, write-zero clears
// - parity flag sets on error, write-zero clears; not set when a framing error comes with it
// - tx done sets idle or last bit
// - tx done clears with tx empty
// - rx multiproc bit captured, held when disabled
// - tx multiproc bit appended to sent characters
// - eight-bit divisor register resets to all ones
// - rate from divisor and prescaler select
// - period (N+1)*64 or 8 times 2^(2n-1)
// - skip mode drops zero-bit characters silently
//
// The APB slave port and the register addresses were decided locally.
`timescale 1ns/1ps
module ssb_top
  import ssb_pkg::*;
(
  // clock and reset
  input  wire logic       i_clk,
  input  wire logic       i_sys_rst,
  // apb slave
  input  wire logic       i_psel,
  input  wire logic       i_penable,
  input  wire logic       i_pwrite,
  input  wire logic [7:0] i_paddr,
  input  wire logic [31:0] i_pwdata,
  input  wire logic [3:0] i_pstrb,
  output logic [31:0]     o_prdata,
  output logic            o_pready,
  output logic            o_pslverr,
  // transmit shifter side
  output logic [7:0]      o_tx_data,
  output logic            o_tx_mpb,
  output logic            o_tx_pending,
  input  wire logic       i_tx_load,
  input  wire logic       i_tx_last_bit,
  // receive shifter side
  input  wire logic       i_rx_valid,
  output logic            o_rx_ready,
  input  wire logic [7:0] i_rx_data,
  input  wire logic       i_rx_mpb,
  input  wire logic       i_rx_framing_err,
  input  wire logic       i_rx_parity_err,
  // mode outputs and bit clock
  output logic            o_transmit_enable,
  output logic            o_receive_enable,
  output logic            o_sync_mode,
  output logic            o_bit_tick
);
  import ssb_pkg::*;

  function automatic logic reg_hit(input logic [7:0] addr, input logic [7:0] off);
    reg_hit = (addr == off);
  endfunction

  // software-visible state
  logic       tx_holding_empty;
  logic       rx_holding_full;
  logic       overrun_flag;
  logic       framing_error_flag;
  logic       parity_error_flag;
  logic       tx_complete_flag;
  logic       rx_multiproc_bit;
  logic       tx_multiproc_bit;
  logic [7:0] bit_rate_divisor;
  logic       transmit_enable;
  logic       receive_enable;
  logic       multiproc_skip_enable;
  logic       sync_mode;
  logic [1:0] prescaler_select;
  logic [7:0] tx_holding_reg;
  logic [7:0] rx_holding_reg;

  // flags seen as one by a status read
  logic       seen_tx_empty;
  logic       seen_rx_full;
  logic       seen_overrun;
  logic       seen_framing;
  logic       seen_parity;

  // bus decode
  logic       access;
  logic       wr_en;
  logic       rd_en;
  logic       lane0;
  logic       mapped;
  logic       wr_status;
  logic       wr_divisor;
  logic       wr_control;
  logic       wr_tx_data;
  logic       rd_status;
  logic       rd_rx_data;
  logic [7:0] status_byte;
  logic [7:0] wbyte;

  assign access     = i_psel & i_penable;
  assign wr_en      = access & i_pwrite;
  assign rd_en      = access & ~i_pwrite;
  assign lane0      = i_pstrb[0];
  assign wbyte      = i_pwdata[7:0];
  assign mapped     = reg_hit(i_paddr, SSB_OFF_STATUS) | reg_hit(i_paddr, SSB_OFF_DIVISOR) |
                      reg_hit(i_paddr, SSB_OFF_CONTROL) | reg_hit(i_paddr, SSB_OFF_TX_DATA) |
                      reg_hit(i_paddr, SSB_OFF_RX_DATA);
  assign wr_status  = wr_en & lane0 & reg_hit(i_paddr, SSB_OFF_STATUS);
  assign wr_divisor = wr_en & lane0 & reg_hit(i_paddr, SSB_OFF_DIVISOR);
  assign wr_control = wr_en & lane0 & reg_hit(i_paddr, SSB_OFF_CONTROL);
  assign wr_tx_data = wr_en & lane0 & reg_hit(i_paddr, SSB_OFF_TX_DATA);
  assign rd_status  = rd_en & reg_hit(i_paddr, SSB_OFF_STATUS);
  assign rd_rx_data = rd_en & reg_hit(i_paddr, SSB_OFF_RX_DATA);

  // zero-wait slave; an unmapped address answers with an error
  assign o_pready   = 1'b1;
  assign o_pslverr  = access & ~mapped;

  assign status_byte = {tx_holding_empty, rx_holding_full, overrun_flag, framing_error_flag,
                        parity_error_flag, tx_complete_flag, rx_multiproc_bit, tx_multiproc_bit};

  // read data is latched in the setup cycle so it comes from a flop during access
  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      o_prdata <= '0;
    end else if (i_psel && !i_penable && !i_pwrite) begin
      o_prdata <= '0;
      unique case (1'b1)
        reg_hit(i_paddr, SSB_OFF_STATUS):  o_prdata[7:0] <= status_byte;
        reg_hit(i_paddr, SSB_OFF_DIVISOR): o_prdata[7:0] <= bit_rate_divisor;
        reg_hit(i_paddr, SSB_OFF_CONTROL): o_prdata[7:0] <= {2'b00, prescaler_select, sync_mode,
                                                             multiproc_skip_enable, receive_enable,
                                                             transmit_enable};
        reg_hit(i_paddr, SSB_OFF_RX_DATA): o_prdata[7:0] <= rx_holding_reg;
        default:                           o_prdata <= '0;
      endcase
    end
  end

  // a write of zero clears only a flag that an earlier read returned as one
  logic clr_tx_empty;
  logic clr_rx_full;
  logic clr_overrun;
  logic clr_framing;
  logic clr_parity;

  assign clr_tx_empty = wr_status & ~wbyte[SSB_ST_TX_EMPTY] & seen_tx_empty;
  assign clr_rx_full  = wr_status & ~wbyte[SSB_ST_RX_FULL] & seen_rx_full;
  assign clr_overrun  = wr_status & ~wbyte[SSB_ST_OVERRUN] & seen_overrun;
  assign clr_framing  = wr_status & ~wbyte[SSB_ST_FRAMING] & seen_framing;
  assign clr_parity   = wr_status & ~wbyte[SSB_ST_PARITY] & seen_parity;

  // a seen mark lives until the next status write or until its flag drops
  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      seen_tx_empty <= 1'b0;
      seen_rx_full  <= 1'b0;
      seen_overrun  <= 1'b0;
      seen_framing  <= 1'b0;
      seen_parity   <= 1'b0;
    end else if (wr_status) begin
      seen_tx_empty <= 1'b0;
      seen_rx_full  <= 1'b0;
      seen_overrun  <= 1'b0;
      seen_framing  <= 1'b0;
      seen_parity   <= 1'b0;
    end else begin
      seen_tx_empty <= (seen_tx_empty | rd_status & o_prdata[SSB_ST_TX_EMPTY]) & tx_holding_empty;
      seen_rx_full  <= (seen_rx_full | rd_status & o_prdata[SSB_ST_RX_FULL]) & rx_holding_full;
      seen_overrun  <= (seen_overrun | rd_status & o_prdata[SSB_ST_OVERRUN]) & overrun_flag;
      seen_framing  <= (seen_framing | rd_status & o_prdata[SSB_ST_FRAMING]) & framing_error_flag;
      seen_parity   <= (seen_parity | rd_status & o_prdata[SSB_ST_PARITY]) & parity_error_flag;
    end
  end

  // configuration registers
  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      bit_rate_divisor <= SSB_RST_DIVISOR;
    end else if (wr_divisor) begin
      bit_rate_divisor <= wbyte;
    end
  end

  logic rx_accept;
  logic rx_skip;
  logic rx_wake;

  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      transmit_enable  <= SSB_RST_CONTROL[SSB_CT_TX_EN];
      receive_enable   <= SSB_RST_CONTROL[SSB_CT_RX_EN];
      sync_mode        <= SSB_RST_CONTROL[SSB_CT_SYNC];
      prescaler_select <= SSB_RST_CONTROL[SSB_CT_PRESC_HI:SSB_CT_PRESC_LO];
    end else if (wr_control) begin
      transmit_enable  <= wbyte[SSB_CT_TX_EN];
      receive_enable   <= wbyte[SSB_CT_RX_EN];
      sync_mode        <= wbyte[SSB_CT_SYNC];
      prescaler_select <= wbyte[SSB_CT_PRESC_HI:SSB_CT_PRESC_LO];
    end
  end

  // skip mode is armed by software and dropped by a character that carries a one
  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      multiproc_skip_enable <= SSB_RST_CONTROL[SSB_CT_SKIP_EN];
    end else if (wr_control) begin
      multiproc_skip_enable <= wbyte[SSB_CT_SKIP_EN];
    end else if (rx_wake) begin
      multiproc_skip_enable <= 1'b0;
    end
  end

  // transmit side
  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      tx_holding_reg <= '0;
    end else if (wr_tx_data) begin
      tx_holding_reg <= wbyte;
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      tx_multiproc_bit <= SSB_RST_STATUS[SSB_ST_TX_MPB];
    end else if (wr_status) begin
      tx_multiproc_bit <= wbyte[SSB_ST_TX_MPB];
    end
  end

  // set wins over clear so a load in the clearing cycle is not lost
  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      tx_holding_empty <= SSB_RST_STATUS[SSB_ST_TX_EMPTY];
    end else if (!transmit_enable || i_tx_load) begin
      tx_holding_empty <= 1'b1;
    end else if (clr_tx_empty || wr_tx_data) begin
      tx_holding_empty <= 1'b0;
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      tx_complete_flag <= SSB_RST_STATUS[SSB_ST_TX_DONE];
    end else if (!transmit_enable || (i_tx_last_bit && tx_holding_empty)) begin
      tx_complete_flag <= 1'b1;
    end else if (clr_tx_empty || wr_tx_data) begin
      tx_complete_flag <= 1'b0;
    end
  end

  assign o_tx_data    = tx_holding_reg;
  assign o_tx_mpb     = tx_multiproc_bit;
  assign o_tx_pending = transmit_enable & ~tx_holding_empty;

  // receive side: sort each arriving character before it reaches the buffer
  logic       fifo_in_valid;
  logic       fifo_in_ready;
  logic       fifo_out_valid;
  logic       fifo_out_ready;
  logic [8:0] fifo_out_data;
  logic       set_overrun;
  logic       set_framing;
  logic       set_parity;
  logic       rx_clean;

  assign rx_accept     = i_rx_valid & receive_enable;
  assign rx_skip       = rx_accept & multiproc_skip_enable & ~i_rx_mpb;
  assign rx_wake       = rx_accept & multiproc_skip_enable & i_rx_mpb;
  assign set_framing   = rx_accept & ~rx_skip & i_rx_framing_err;
  assign set_parity    = rx_accept & ~rx_skip & ~i_rx_framing_err & i_rx_parity_err;
  assign rx_clean      = rx_accept & ~rx_skip & ~i_rx_framing_err & ~i_rx_parity_err;
  // the line cannot be stalled, so a character the full buffer refuses is an overrun
  assign set_overrun   = rx_clean & ~fifo_in_ready;
  assign fifo_in_valid = rx_clean;
  assign o_rx_ready    = fifo_in_ready;

  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      rx_multiproc_bit <= SSB_RST_STATUS[SSB_ST_RX_MPB];
    end else if (rx_accept && !rx_skip) begin
      rx_multiproc_bit <= i_rx_mpb;
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      overrun_flag <= SSB_RST_STATUS[SSB_ST_OVERRUN];
    end else if (set_overrun) begin
      overrun_flag <= 1'b1;
    end else if (clr_overrun) begin
      overrun_flag <= 1'b0;
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      framing_error_flag <= SSB_RST_STATUS[SSB_ST_FRAMING];
    end else if (set_framing) begin
      framing_error_flag <= 1'b1;
    end else if (clr_framing) begin
      framing_error_flag <= 1'b0;
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      parity_error_flag <= SSB_RST_STATUS[SSB_ST_PARITY];
    end else if (set_parity) begin
      parity_error_flag <= 1'b1;
    end else if (clr_parity) begin
      parity_error_flag <= 1'b0;
    end
  end

  // the holding register takes the next byte only once software has emptied it
  assign fifo_out_ready = ~rx_holding_full;

  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      rx_holding_reg <= '0;
    end else if (fifo_out_valid && fifo_out_ready) begin
      rx_holding_reg <= fifo_out_data[7:0];
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      rx_holding_full <= SSB_RST_STATUS[SSB_ST_RX_FULL];
    end else if (fifo_out_valid && fifo_out_ready) begin
      rx_holding_full <= 1'b1;
    end else if (clr_rx_full || rd_rx_data) begin
      rx_holding_full <= 1'b0;
    end
  end

  ssb_fifo #(
    .WIDTH (SSB_RX_WIDTH),
    .DEPTH (SSB_RX_DEPTH)
  ) u_rx_fifo (
    .i_clk       (i_clk),
    .i_sys_rst   (i_sys_rst),
    .i_in_valid  (fifo_in_valid),
    .o_in_ready  (fifo_in_ready),
    .i_in_data   ({i_rx_mpb, i_rx_data}),
    .o_out_valid (fifo_out_valid),
    .i_out_ready (fifo_out_ready),
    .o_out_data  (fifo_out_data)
  );

  // bit clock from divisor and prescaler select
  ssb_rate_gen u_rate (
    .i_clk       (i_clk),
    .i_sys_rst   (i_sys_rst),
    .i_enable    (transmit_enable | receive_enable),
    .i_sync_mode (sync_mode),
    .i_presc_sel (prescaler_select),
    .i_divisor   (bit_rate_divisor),
    .o_bit_tick  (o_bit_tick)
  );

  assign o_transmit_enable = transmit_enable;
  assign o_receive_enable  = receive_enable;
  assign o_sync_mode       = sync_mode;
endmodule

// *** ssb_top_properties.sv ***
// concurrent checks on the ports of the serial status and bit-rate block
`timescale 1ns/1ps
module ssb_top_properties
  import ssb_pkg::*;
(
  // clock and reset
  input wire logic        i_clk,
  input wire logic        i_sys_rst,
  // apb
  input wire logic        i_psel,
  input wire logic        i_penable,
  input wire logic        i_pwrite,
  input wire logic [7:0]  i_paddr,
  input wire logic [3:0]  i_pstrb,
  input wire logic [31:0] o_prdata,
  input wire logic        o_pready,
  input wire logic        o_pslverr,
  // shifter and mode
  input wire logic        o_tx_mpb,
  input wire logic        o_tx_pending,
  input wire logic        i_tx_load,
  input wire logic        o_rx_ready,
  input wire logic        o_transmit_enable,
  input wire logic        o_receive_enable,
  input wire logic        o_bit_tick
);
  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (i_sys_rst);
  logic acc;
  logic mapped;
  logic idle;
  logic wr_tx;
  assign acc    = i_psel & i_penable;
  assign mapped = i_paddr inside {SSB_OFF_STATUS, SSB_OFF_DIVISOR, SSB_OFF_CONTROL, SSB_OFF_TX_DATA, SSB_OFF_RX_DATA};
  assign idle   = !o_transmit_enable && !o_receive_enable;
  assign wr_tx  = acc && i_pwrite && i_pstrb[0] && i_paddr == SSB_OFF_TX_DATA;

  a_ready_always: assert property (o_pready)
    else $error("pready low");
  a_unmapped_refused: assert property (acc && !mapped && !i_pwrite |-> o_pslverr && o_prdata == 32'h0)
    else $error("unmapped read not refused");
  a_mapped_ok: assert property (acc && mapped |-> !o_pslverr)
    else $error("mapped access refused");
  a_write_pending: assert property (wr_tx && o_transmit_enable && !i_tx_load |=> o_tx_pending)
    else $error("byte write left holding empty");
  a_load_empties: assert property (i_tx_load && !wr_tx |=> !o_tx_pending)
    else $error("load did not empty holding");
  a_disabled_empty: assert property (!o_transmit_enable ##1 o_transmit_enable |-> !o_tx_pending)
    else $error("pending right after transmit enable");
  a_mpb_hold: assert property (!(acc && i_pwrite && i_paddr == SSB_OFF_STATUS) |=> $stable(o_tx_mpb))
    else $error("tx multiproc bit moved");
  a_tick_gap: assert property (o_bit_tick |=> !o_bit_tick [*3])
    else $error("ticks too close");
  a_tick_quiet: assert property (idle ##1 idle |-> !o_bit_tick)
    else $error("tick while both enables off");
  a_empty_read: assert property (acc && !i_pwrite && i_paddr == SSB_OFF_STATUS
                                 |-> o_prdata[SSB_ST_TX_EMPTY] == !$past(o_tx_pending))
    else $error("status empty bit disagrees with pending");
  a_high_zero: assert property (acc && !i_pwrite |-> o_prdata[31:8] == 24'h0)
    else $error("upper read bits set");

  c_tick: cover property (o_bit_tick);
  c_refused: cover property (acc && !mapped);
  c_rx_full: cover property (!o_rx_ready);
  c_tx_load: cover property (i_tx_load && o_transmit_enable);
endmodule

bind ssb_top ssb_top_properties ssb_top_properties_i (.i_clk, .i_sys_rst, .i_psel, .i_penable, .i_pwrite,
  .i_paddr, .i_pstrb, .o_prdata, .o_pready, .o_pslverr, .o_tx_mpb, .o_tx_pending, .i_tx_load, .o_rx_ready,
  .o_transmit_enable, .o_receive_enable, .o_bit_tick);

// *** ssb_shifter_model.sv ***
// shifter-side model: takes the held byte after a stall, delivers characters on command
`timescale 1ns/1ps
module ssb_shifter_model (
  // clock and reset
  input  wire logic       i_clk,
  input  wire logic       i_sys_rst,
  // transmit side
  input  wire logic       i_tx_pending,
  input  wire logic [7:0] i_tx_data,
  input  wire logic       i_tx_mpb,
  output logic            o_tx_load,
  output logic            o_tx_last_bit,
  // receive side
  output logic            o_rx_valid,
  output logic [7:0]      o_rx_data,
  output logic            o_rx_mpb,
  output logic            o_rx_framing_err,
  output logic            o_rx_parity_err
);
  int         tx_delay = 20;
  logic [8:0] sent[$];

  initial begin
    o_tx_load = 1'b0;
    o_tx_last_bit = 1'b0;
    o_rx_valid = 1'b0;
    o_rx_data = 8'h00;
    o_rx_mpb = 1'b0;
    o_rx_framing_err = 1'b0;
    o_rx_parity_err = 1'b0;
    forever begin
      @(posedge i_clk);
      if (i_tx_pending === 1'b1 && !i_sys_rst) begin
        // a slow shifter: the held byte waits while an earlier frame drains
        repeat (tx_delay) @(posedge i_clk);
        sent.push_back({i_tx_mpb, i_tx_data});
        o_tx_load <= 1'b1;
        @(posedge i_clk);
        o_tx_load <= 1'b0;
        repeat (9) @(posedge i_clk);
        o_tx_last_bit <= 1'b1;
        @(posedge i_clk);
        o_tx_last_bit <= 1'b0;
      end
    end
  end

  // idle lines show the inverse of the last character, never a stale copy
  task automatic send(input logic [7:0] d, input logic m, input logic fe, input logic pe);
    @(posedge i_clk);
    o_rx_valid <= 1'b1;
    o_rx_data <= d;
    o_rx_mpb <= m;
    o_rx_framing_err <= fe;
    o_rx_parity_err <= pe;
    @(posedge i_clk);
    o_rx_valid <= 1'b0;
    o_rx_data <= ~d;
    o_rx_mpb <= ~m;
    o_rx_framing_err <= ~fe;
    o_rx_parity_err <= ~pe;
  endtask
endmodule

// *** ssb_top_tb.sv ***
// self-checking bench: apb traffic, a shifter model and a reference of the status bits
`timescale 1ns/1ps
module ssb_top_tb;
  import ssb_pkg::*;
  logic        i_clk, i_sys_rst, i_psel, i_penable, i_pwrite, i_tx_load, i_tx_last_bit, perr;
  logic        i_rx_valid, i_rx_mpb, i_rx_framing_err, i_rx_parity_err, o_pready, o_pslverr, o_tx_mpb;
  logic        o_tx_pending, o_rx_ready, o_transmit_enable, o_receive_enable, o_sync_mode, o_bit_tick;
  logic [7:0]  i_paddr, i_rx_data, o_tx_data, d;
  logic [3:0]  i_pstrb;
  logic [31:0] i_pwdata, o_prdata, r;
  logic [31:0] seed = 32'd8104;
  logic [7:0]  rxq[$];
  int          fail_count = 0;
  int          num_checks = 0;
  int          cyc = 0;
  int          st, k, nn;

  ssb_top ssb_top_i (.i_clk, .i_sys_rst, .i_psel, .i_penable, .i_pwrite, .i_paddr, .i_pwdata, .i_pstrb,
    .o_prdata, .o_pready, .o_pslverr, .o_tx_data, .o_tx_mpb, .o_tx_pending, .i_tx_load, .i_tx_last_bit,
    .i_rx_valid, .o_rx_ready, .i_rx_data, .i_rx_mpb, .i_rx_framing_err, .i_rx_parity_err,
    .o_transmit_enable, .o_receive_enable, .o_sync_mode, .o_bit_tick);
  ssb_shifter_model ssb_shifter_model_i (.i_clk, .i_sys_rst, .i_tx_pending(o_tx_pending), .i_tx_data(o_tx_data),
    .i_tx_mpb(o_tx_mpb), .o_tx_load(i_tx_load), .o_tx_last_bit(i_tx_last_bit), .o_rx_valid(i_rx_valid),
    .o_rx_data(i_rx_data), .o_rx_mpb(i_rx_mpb), .o_rx_framing_err(i_rx_framing_err),
    .o_rx_parity_err(i_rx_parity_err));

  initial begin
    i_clk = 1'b0;
    forever #2 i_clk = ~i_clk;
  end

  // the longest bit-rate case needs about 16k cycles
  always @(posedge i_clk) begin
    cyc <= cyc + 1;
    if (cyc == 60000) begin
      fail_count++;
      results();
    end
  end

  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction

  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] wd);
    @(posedge i_clk);
    i_psel <= 1'b1;
    i_penable <= 1'b0;
    i_pwrite <= w;
    i_paddr <= a;
    i_pwdata <= wd;
    @(posedge i_clk);
    i_penable <= 1'b1;
    k = 0;
    do begin
      @(posedge i_clk);
      k++;
    end while (o_pready !== 1'b1 && k < 50);
    r = o_prdata;
    perr = o_pslverr;
    i_psel <= 1'b0;
    i_penable <= 1'b0;
  endtask

  task automatic chk(input string s, input logic [31:0] e, input logic [31:0] g);
    num_checks++;
    if (g !== e) begin
      fail_count++;
      $display("Error %s expected %h seen %h", s, e, g);
    end
  endtask

  task automatic stat();
    apb(1'b0, SSB_OFF_STATUS, 32'h0);
    chk("status", st, r);
  endtask

  task automatic ctl(input logic [7:0] c);
    apb(1'b1, SSB_OFF_CONTROL, {24'h0, c});
  endtask

  task automatic tk();
    k = 0;
    do begin
      @(negedge i_clk);
      k++;
    end while (o_bit_tick !== 1'b1 && k < 9000);
  endtask

  task automatic results();
    $display("checks %0d mismatches %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  initial begin
    i_sys_rst = 1'b1;
    i_psel = 1'b0;
    i_penable = 1'b0;
    i_pwrite = 1'b0;
    i_paddr = 8'h00;
    i_pwdata = 32'h0;
    i_pstrb = 4'hf;
    repeat (20) @(posedge i_clk);
    i_sys_rst <= 1'b0;
    st = 8'h84;
    stat();
    i_pstrb <= 4'he;
    apb(1'b1, SSB_OFF_DIVISOR, 32'h0);
    i_pstrb <= 4'hf;
    apb(1'b0, SSB_OFF_DIVISOR, 32'h0);
    chk("divisor", 32'hff, r);
    apb(1'b1, SSB_OFF_STATUS, 32'hff);
    st = 8'h85;
    stat();
    apb(1'b0, 8'h14, 32'h0);
    chk("refused", 32'h1, {r[30:0], perr});
    // control bit3 sync, bits 5:4 prescaler: m[0] picks sync, m[2:1] the prescaler
    for (int m = 0; m < 8; m++) begin
      nn = rnd() & 3;
      apb(1'b1, SSB_OFF_DIVISOR, nn);
      apb(1'b0, SSB_OFF_DIVISOR, 32'h0);
      chk("divisor", nn, r);
      ctl(8'h00);
      ctl(8'h01 | 8'(m << 3));
      tk();
      tk();
      chk("mode", (m & 1) * 2 + 1, {30'h0, o_sync_mode, o_transmit_enable});
      chk("period", (nn + 1) * ((m & 1) ? 4 : 32) * (4 ** (m >> 1)), k);
    end
    ctl(8'h01);
    d = 8'(rnd());
    apb(1'b1, SSB_OFF_TX_DATA, {24'h0, d});
    st = 8'h01;
    stat();
    k = 0;
    while (i_tx_last_bit !== 1'b1 && k < 100) begin
      @(negedge i_clk);
      k++;
    end
    st = 8'h85;
    stat();
    chk("sent", {23'h0, 1'b1, d}, ssb_shifter_model_i.sent[0]);
    ssb_shifter_model_i.tx_delay = 200;
    apb(1'b1, SSB_OFF_STATUS, 32'hff);
    apb(1'b1, SSB_OFF_STATUS, 32'h01);
    stat();
    apb(1'b1, SSB_OFF_STATUS, 32'h01);
    st = 8'h01;
    stat();
    ctl(8'h02);
    st = 8'h85;
    stat();
    d = 8'(rnd());
    ssb_shifter_model_i.send(d, 1'b1, 1'b0, 1'b0);
    st = 8'hc7;
    stat();
    apb(1'b0, SSB_OFF_RX_DATA, 32'h0);
    chk("rx data", {24'h0, d}, r);
    st = 8'h87;
    stat();
    ssb_shifter_model_i.send(8'(rnd()), 1'b1, 1'b1, 1'b0);
    ssb_shifter_model_i.send(8'(rnd()), 1'b1, 1'b0, 1'b1);
    st = 8'h9f;
    stat();
    apb(1'b1, SSB_OFF_STATUS, 32'h01);
    st = 8'h87;
    stat();
    for (int j = 0; j < 10; j++) begin
      d = 8'(rnd());
      if (j < 9) rxq.push_back(d);
      ssb_shifter_model_i.send(d, 1'b1, 1'b0, 1'b0);
    end
    @(negedge i_clk);
    chk("rx ready", 32'h0, {31'h0, o_rx_ready});
    st = 8'he7;
    stat();
    while (rxq.size() > 0) begin
      apb(1'b0, SSB_OFF_RX_DATA, 32'h0);
      chk("rx data", {24'h0, rxq.pop_front()}, r);
    end
    st = 8'ha7;
    stat();
    apb(1'b1, SSB_OFF_STATUS, 32'h01);
    st = 8'h87;
    stat();
    ctl(8'h06);
    ssb_shifter_model_i.send(8'(rnd()), 1'b0, 1'b1, 1'b0);
    chk("enables", 32'h2, {30'h0, o_receive_enable, o_transmit_enable});
    stat();
    d = 8'(rnd());
    ssb_shifter_model_i.send(d, 1'b1, 1'b0, 1'b0);
    apb(1'b0, SSB_OFF_CONTROL, 32'h0);
    chk("control", 32'h2, r);
    apb(1'b0, SSB_OFF_RX_DATA, 32'h0);
    chk("rx data", {24'h0, d}, r);
    ssb_shifter_model_i.send(8'(rnd()), 1'b0, 1'b0, 1'b0);
    st = 8'hc5;
    stat();
    ctl(8'h00);
    ssb_shifter_model_i.send(8'(rnd()), 1'b1, 1'b0, 1'b0);
    stat();
    apb(1'b1, SSB_OFF_STATUS, 32'h01);
    st = 8'h85;
    stat();
    results();
  end
endmodule
